// File: verilog/rbms_regs.svh
/*
 * register offsets, field positions, reset values and timing counts for
 * the boot mode and memory source select block.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef RBMS_REGS_SVH
`define RBMS_REGS_SVH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define RBMS_CTRL_OFS      8'h00
`define RBMS_STAT_OFS      8'h04

// ---------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------
`define RBMS_CTRL_TSC_BIT  5
`define RBMS_CTRL_RST      32'h0000_0000
`define RBMS_STAT_MODE_BIT 0
`define RBMS_STAT_XSEL_BIT 1
`define RBMS_STAT_XBUS_BIT 2

// ---------------------------------------------------------------------
// memory map and reset vector
// ---------------------------------------------------------------------
`define RBMS_ROM_BASE      16'hF800
`define RBMS_ROM_TOP       16'hFFFF
`define RBMS_VEC_LO        16'hFFFC
`define RBMS_VEC_HI        16'hFFFD

// ---------------------------------------------------------------------
// timing: strap must be low one clock after release (4 ns at 250 MHz); the design samples the pin at the second clock
// ---------------------------------------------------------------------
`define RBMS_CLK_PS        4000
`define RBMS_STRAP_HOLD_PS 4000
`define RBMS_STRAP_HOLD_CY \
    ((`RBMS_STRAP_HOLD_PS + `RBMS_CLK_PS - 1) / `RBMS_CLK_PS)

`endif

// File: verilog/rbms_pkg.sv
/*
 * types for the boot mode and memory source select block.
 * assumes rbms_regs.svh on the include path.
 */
`default_nettype none
package rbms_pkg;
    `include "rbms_regs.svh"

    // -----------------------------------------------------------------
    // processor-side memory request and answer
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rbms_cpu_req_t;

    typedef struct packed {
        logic        ext_cycle;
        logic        int_rom_sel;
        logic [7:0]  rdata;
    } rbms_cpu_rsp_t;

    typedef enum logic [3:0] {
        RBMS_ST_RESET  = 4'b0001,
        RBMS_ST_SAMPLE = 4'b0010,
        RBMS_ST_VECTOR = 4'b0100,
        RBMS_ST_RUN    = 4'b1000
    } rbms_state_t;
endpackage
`default_nettype wire

// File: verilog/rbms_boot_ctl.sv
/*
 * boot mode latch, reset vector fetch and rom source switching, with an
 * axi4-lite slave for the bus control bit and a status word.
 * assumes one 250 MHz clock; strap and select pins are asynchronous and
 * are synchronised here; internal rom and external data buses sit outside.
 */
`default_nettype none

`include "rbms_regs.svh"

// Functional notes
// - strap high at reset release selects normal mode, internal rom on top.
// - normal mode fetches reset vector from internal rom FFFC low, FFFD high.
// - normal mode expansion accesses happen only after tristate bit set.
// - prototype mode maps external memory over F800 to FFFF.
// - strap low at reset release selects prototype mode.
// - prototype mode reads reset vector from external FFFC and FFFD.
// - prototype mode ignores the tristate control bit.
// - prototype mode uses rom select pin; high selects external memory.
// - rom select line is high after reset, external memory by default.
// - low rom select restores internal rom in prototype mode.
// - normal mode expansion bus active only while tristate bit set.
// - prototype rom region always drives external bus; only data switches.
module rbms_boot_ctl (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    // pins
    input  wire logic                  i_bus_enable_strap,
    input  wire logic                  i_external_rom_select,
    output logic                       o_external_rom_select_o,
    output logic                       o_external_rom_select_oe,
    // processor side
    input  wire rbms_pkg::rbms_cpu_req_t i_cpu_req,
    output rbms_pkg::rbms_cpu_rsp_t    o_cpu_rsp,
    output logic                       o_vec_valid,
    output logic [15:0]                o_vec_addr,
    output logic                       o_cpu_run,
    // memory data sources
    input  wire logic [7:0]            i_int_rom_data,
    input  wire logic [7:0]            i_ext_data,
    // expansion bus
    output logic                       o_xbus_active,
    output logic [15:0]                o_xbus_addr,
    // axi4-lite slave
    input  wire logic [7:0]            i_awaddr,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    input  wire logic [7:0]            i_araddr,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready
);
    import rbms_pkg::*;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] strap_sync_reg;
    logic [1:0] xsel_sync_reg;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_sync_reg <= 2'h3;
            xsel_sync_reg  <= 2'h3;
        end else begin
            strap_sync_reg <= {strap_sync_reg[0], i_bus_enable_strap};
            xsel_sync_reg  <= {xsel_sync_reg[0], i_external_rom_select};
        end
    end

    // -----------------------------------------------------------------
    // boot sequence
    // -----------------------------------------------------------------
    rbms_state_t state_reg;
    rbms_state_t state_next;
    logic        proto_mode_reg;
    logic        vec_hi_reg;
    logic [2:0]  wait_reg;

    // strap reaches the sampler after the synchroniser, so the sample is
    // taken four clocks after release, from the strap seen at the second clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RBMS_ST_RESET:  state_next = RBMS_ST_SAMPLE;
            RBMS_ST_SAMPLE: begin
                if (wait_reg == 3'h0) begin
                    state_next = RBMS_ST_VECTOR;
                end
            end
            RBMS_ST_VECTOR: begin
                if (vec_hi_reg) begin
                    state_next = RBMS_ST_RUN;
                end
            end
            RBMS_ST_RUN:    state_next = RBMS_ST_RUN;
            default:        state_next = RBMS_ST_RESET;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= RBMS_ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_reg <= 3'h2;
        end else if (state_reg == RBMS_ST_SAMPLE && wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end
    end

    // mode caught once, at the end of the sample window
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            proto_mode_reg <= 1'b0;
        end else if (state_reg == RBMS_ST_SAMPLE && wait_reg == 3'h0) begin
            proto_mode_reg <= ~strap_sync_reg[1];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            vec_hi_reg <= 1'b0;
        end else if (state_reg == RBMS_ST_VECTOR) begin
            vec_hi_reg <= 1'b1;
        end
    end

    // vector fetch: low byte then high byte
    logic vec_phase;
    assign vec_phase  = (state_reg == RBMS_ST_VECTOR);
    assign o_vec_valid = vec_phase;
    assign o_vec_addr  = vec_hi_reg ? `RBMS_VEC_HI : `RBMS_VEC_LO;
    assign o_cpu_run   = (state_reg == RBMS_ST_RUN);

    // -----------------------------------------------------------------
    // memory source selection
    // -----------------------------------------------------------------
    function automatic logic in_rom_region(input logic [15:0] a);
        in_rom_region = (a >= `RBMS_ROM_BASE) && (a <= `RBMS_ROM_TOP);
    endfunction

    logic        tsc_reg;
    logic [15:0] cur_addr;
    logic        cur_valid;
    logic        in_rom;
    logic        use_ext;

    assign cur_addr  = vec_phase ? o_vec_addr : i_cpu_req.addr;
    assign cur_valid = vec_phase | (o_cpu_run & i_cpu_req.valid);
    assign in_rom    = in_rom_region(cur_addr);
    // pin defaults high through the synchroniser reset value
    assign use_ext   = proto_mode_reg & xsel_sync_reg[1];

    // -----------------------------------------------------------------
    // expansion bus gating
    // -----------------------------------------------------------------
    logic ext_cycle;
    always_comb begin
        if (proto_mode_reg) begin
            ext_cycle = cur_valid;
        end else begin
            ext_cycle = cur_valid & tsc_reg & ~in_rom;
        end
    end

    logic [15:0] xaddr_reg;
    logic        xact_reg;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            xact_reg  <= 1'b0;
            xaddr_reg <= 16'h0000;
        end else begin
            xact_reg  <= ext_cycle;
            xaddr_reg <= ext_cycle ? cur_addr : xaddr_reg;
        end
    end
    assign o_xbus_active = xact_reg;
    assign o_xbus_addr   = xaddr_reg;

    rbms_cpu_rsp_t rsp_reg;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.ext_cycle   <= ext_cycle;
            rsp_reg.int_rom_sel <= in_rom & ~use_ext;
            // only returned data switches between sources
            if (in_rom && !use_ext) begin
                rsp_reg.rdata <= i_int_rom_data;
            end else begin
                rsp_reg.rdata <= i_ext_data;
            end
        end
    end
    assign o_cpu_rsp = rsp_reg;

    // pin is input-only here; never driven
    assign o_external_rom_select_o  = 1'b1;
    assign o_external_rom_select_oe = 1'b0;

    // -----------------------------------------------------------------
    // axi4-lite slave
    // -----------------------------------------------------------------
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        do_write;

    assign o_awready = ~aw_full_reg & ~bvalid_reg;
    assign o_wready  = ~w_full_reg & ~bvalid_reg;
    assign do_write  = aw_full_reg & w_full_reg & ~bvalid_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (i_awvalid && o_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tsc_reg <= 1'(`RBMS_CTRL_RST >> `RBMS_CTRL_TSC_BIT);
        end else if (do_write && aw_addr_reg == `RBMS_CTRL_OFS
                     && w_strb_reg[0]) begin
            tsc_reg <= w_data_reg[`RBMS_CTRL_TSC_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= 2'h0;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (aw_addr_reg == `RBMS_CTRL_OFS) ? 2'h0 : 2'h2;
        end else if (i_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign o_bvalid = bvalid_reg;
    assign o_bresp  = bresp_reg;

    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    assign o_arready = ~rvalid_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'h0;
        end else if (i_arvalid && o_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= 2'h0;
            rdata_reg  <= 32'h0000_0000;
            case (i_araddr)
                `RBMS_CTRL_OFS: begin
                    rdata_reg[`RBMS_CTRL_TSC_BIT] <= tsc_reg;
                end
                `RBMS_STAT_OFS: begin
                    rdata_reg[`RBMS_STAT_MODE_BIT] <= proto_mode_reg;
                    rdata_reg[`RBMS_STAT_XSEL_BIT] <= use_ext;
                    rdata_reg[`RBMS_STAT_XBUS_BIT] <= xact_reg;
                end
                default: rresp_reg <= 2'h2;
            endcase
        end else if (i_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_reg;
    assign o_rdata  = rdata_reg;
    assign o_rresp  = rresp_reg;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence mode_taken_s;
        state_reg == RBMS_ST_SAMPLE && wait_reg == 3'h0;
    endsequence
    mode_latch_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        mode_taken_s and strap_sync_reg[1] |=> !proto_mode_reg)
        else $error("strap high did not give normal mode");
    proto_latch_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        mode_taken_s and !strap_sync_reg[1] |=> proto_mode_reg)
        else $error("strap low did not give prototype mode");
    mode_hold_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        o_cpu_run |=> $stable(proto_mode_reg))
        else $error("boot mode changed after latch");
    vec_order_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        $rose(o_vec_valid) |-> o_vec_addr == `RBMS_VEC_LO
        ##1 o_vec_valid && o_vec_addr == `RBMS_VEC_HI ##1 o_cpu_run)
        else $error("reset vector order wrong");
    vec_extern_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        o_vec_valid && proto_mode_reg |=> o_xbus_active)
        else $error("prototype vector not fetched externally");
    bus_gate_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        !proto_mode_reg && !tsc_reg |=> !o_xbus_active)
        else $error("expansion bus active with tristate bit clear");
    proto_bus_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        proto_mode_reg && o_cpu_run && i_cpu_req.valid
        && in_rom |=> o_xbus_active)
        else $error("rom region access missed external bus");
    rom_switch_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        proto_mode_reg && !xsel_sync_reg[1] && cur_valid && in_rom
        |=> o_cpu_rsp.int_rom_sel)
        else $error("low select did not restore internal rom");
    ext_default_a: assert property (@(posedge i_core_clk)
        disable iff (!i_resetn)
        proto_mode_reg && xsel_sync_reg[1] && cur_valid && in_rom
        |=> !o_cpu_rsp.int_rom_sel)
        else $error("high select did not pick external memory");
endmodule // rbms_boot_ctl
`default_nettype wire

// File: bench/rbms_ext_model.sv
/*
 * far side model: bus enable strap circuit and external memory.
 * assumes the bench supplies the memory address and a select flag.
 */
`default_nettype none
module rbms_ext_model (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    // controls
    input  wire logic        i_proto,
    input  wire logic        i_glitch,
    input  wire logic        i_sel,
    input  wire logic [15:0] i_addr,
    // pins
    output logic             o_strap,
    output logic [7:0]       o_data
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] hold_reg;
    logic [7:0] last_reg = 8'h00;

    // ------------------------------------------------------------
    // strap
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn)
            hold_reg <= 3'h0;
        else if (hold_reg != 3'h4)
            hold_reg <= hold_reg + 3'h1;
    end
    // low through reset and four edges after, high from the first vector on
    assign o_strap = !((i_proto && hold_reg != 3'h4) || i_glitch);

    // ------------------------------------------------------------
    // memory
    // ------------------------------------------------------------
    // released lines toggle so no stale byte can pass as data
    always_ff @(posedge i_core_clk) begin
        last_reg <= o_data;
    end
    assign o_data = i_sel ? (i_addr[7:0] ^ 8'hA5) : ~last_reg;
endmodule // rbms_ext_model
`default_nettype wire

// File: bench/reset_boot_mode_memory_select_test.sv
/*
 * self-checking bench for the boot mode and rom source block.
 * assumes rbms_ext_model as strap circuit and external memory.
 */
`default_nettype none
`include "rbms_regs.svh"
module reset_boot_mode_memory_select_test import rbms_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic        proto;
        logic        expansion_bus_tristate_ctl;
        logic        xsel;
        logic [15:0] addr;
        logic        xbus;
        logic        isel;
    } rbms_row_t;

    logic          i_core_clk = 1'b0;
    logic          i_resetn = 1'b0;
    logic          i_bus_enable_strap;
    logic          i_external_rom_select = 1'b1;
    logic          o_external_rom_select_o;
    logic          o_external_rom_select_oe;
    rbms_cpu_req_t i_cpu_req = '0;
    rbms_cpu_rsp_t o_cpu_rsp;
    logic          o_vec_valid;
    logic          o_cpu_run;
    logic          o_xbus_active;
    logic [15:0]   o_vec_addr;
    logic [15:0]   o_xbus_addr;
    logic [15:0]   m_addr;
    logic          m_sel;
    logic [7:0]    i_int_rom_data;
    logic [7:0]    i_ext_data;
    logic [7:0]    i_awaddr = '0;
    logic [7:0]    i_araddr = '0;
    logic [31:0]   i_wdata = '0;
    logic [3:0]    i_wstrb = '0;
    logic          i_awvalid = 1'b0;
    logic          i_wvalid = 1'b0;
    logic          i_bready = 1'b0;
    logic          i_arvalid = 1'b0;
    logic          i_rready = 1'b0;
    logic          o_awready;
    logic          o_wready;
    logic          o_bvalid;
    logic          o_arready;
    logic          o_rvalid;
    logic [1:0]    o_bresp;
    logic [1:0]    o_rresp;
    logic [31:0]   o_rdata;
    logic          proto = 1'b0;
    logic          glitch = 1'b0;
    logic [31:0]   d;
    logic [1:0]    r;
    rbms_row_t     row;
    int            num_errors = 0;
    int            checked = 0;

    rbms_row_t rows [9] = '{
        '{1'b0, 1'b0, 1'b1, 16'h1000, 1'b0, 1'b0},
        '{1'b0, 1'b1, 1'b1, 16'h1000, 1'b1, 1'b0},
        '{1'b0, 1'b1, 1'b1, 16'hF900, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b0, 1'b1},
        '{1'b1, 1'b0, 1'b1, 16'h1000, 1'b1, 1'b0},
        '{1'b1, 1'b1, 1'b1, 16'h1000, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b1, 16'hF800, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b0, 16'hF900, 1'b1, 1'b1},
        '{1'b1, 1'b1, 1'b0, 16'hF7FF, 1'b1, 1'b0}
    };

    rbms_boot_ctl u_rbms_boot_ctl (
        .i_core_clk, .i_resetn, .i_bus_enable_strap, .i_external_rom_select,
        .o_external_rom_select_o, .o_external_rom_select_oe, .i_cpu_req,
        .o_cpu_rsp, .o_vec_valid, .o_vec_addr, .o_cpu_run, .i_int_rom_data,
        .i_ext_data, .o_xbus_active, .o_xbus_addr, .i_awaddr, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
        .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready);

    rbms_ext_model u_rbms_ext_model (
        .i_core_clk, .i_resetn, .i_proto(proto), .i_glitch(glitch),
        .i_sel(m_sel), .i_addr(m_addr), .o_strap(i_bus_enable_strap),
        .o_data(i_ext_data));

    assign m_sel = o_vec_valid || i_cpu_req.valid;
    assign m_addr = o_vec_valid ? o_vec_addr : i_cpu_req.addr;
    assign i_int_rom_data = m_addr[7:0] ^ 8'h3C;

    function automatic logic [7:0] xd(input logic [15:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction

    function automatic logic [7:0] id(input logic [15:0] a);
        return a[7:0] ^ 8'h3C;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] rs);
        logic rf;
        logic ag;
        logic wg;
        logic bg;
        rf = 1'b1;
        bg = 1'b0;
        @(posedge i_core_clk);
        i_awaddr <= a;
        i_wdata <= v;
        i_wstrb <= 4'hF;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!bg) begin
            @(negedge i_core_clk);
            ag = i_awvalid && o_awready;
            wg = i_wvalid && o_wready;
            bg = o_bvalid;
            rs = o_bresp;
            rf = o_awready | o_wready;
            @(posedge i_core_clk);
            if (ag)
                i_awvalid <= 1'b0;
            if (wg)
                i_wvalid <= 1'b0;
        end
        i_bready <= 1'b0;
        check(32'(rf), 32'h0);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
        logic rf;
        logic ag;
        logic rg;
        rf = 1'b1;
        rg = 1'b0;
        @(posedge i_core_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!rg) begin
            @(negedge i_core_clk);
            ag = i_arvalid && o_arready;
            rg = o_rvalid;
            rf = o_arready;
            v = o_rdata;
            rs = o_rresp;
            @(posedge i_core_clk);
            if (ag)
                i_arvalid <= 1'b0;
        end
        i_rready <= 1'b0;
        check(32'(rf), 32'h0);
    endtask

    // reset, vector fetch, then mode and control readback
    task automatic boot(input logic p);
        int n;
        logic pend;
        logic [7:0] e;
        logic [15:0] va;
        n = 0;
        pend = 1'b0;
        e = 8'h00;
        @(posedge i_core_clk);
        proto <= p;
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        repeat (20) begin
            @(posedge i_core_clk);
            #1;
            if (pend) begin
                check(32'(o_cpu_rsp.rdata), 32'(e));
                check(32'(o_cpu_rsp.int_rom_sel), 32'(!p));
            end
            pend = o_vec_valid;
            if (o_vec_valid) begin
                va = (n == 0) ? `RBMS_VEC_LO : `RBMS_VEC_HI;
                check(32'(o_vec_addr), 32'(va));
                e = p ? xd(va) : id(va);
                n++;
            end
        end
        check(32'(n), 32'h2);
        check(32'(o_cpu_run), 32'h1);
        check(32'(o_external_rom_select_oe), 32'h0);
        check(32'(o_external_rom_select_o), 32'h1);
        axi_rd(`RBMS_STAT_OFS, d, r);
        check(32'(d[`RBMS_STAT_MODE_BIT]), 32'(p));
        if (p)
            check(32'(d[`RBMS_STAT_XSEL_BIT]), 32'h1);
        axi_rd(`RBMS_CTRL_OFS, d, r);
        check(d, `RBMS_CTRL_RST);
    endtask

    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    initial begin
        #20000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        for (int i = 0; i < 9; i++) begin
            row = rows[i];
            if (i == 0 || row.proto != proto)
                boot(row.proto);
            @(posedge i_core_clk);
            i_external_rom_select <= row.xsel;
            axi_wr(`RBMS_CTRL_OFS, {26'h0, row.expansion_bus_tristate_ctl, 5'h0}, r);
            repeat (4) @(posedge i_core_clk);
            i_cpu_req <= '{1'b1, 1'b0, row.addr, 8'h00};
            @(posedge i_core_clk);
            i_cpu_req.valid <= 1'b0;
            #1;
            check(32'(o_xbus_active), 32'(row.xbus));
            check(32'(o_cpu_rsp.ext_cycle), 32'(row.xbus));
            if (row.xbus)
                check(32'(o_xbus_addr), 32'(row.addr));
            if (row.addr >= `RBMS_ROM_BASE) begin
                check(32'(o_cpu_rsp.int_rom_sel), 32'(row.isel));
                e_chk(row);
            end
        end
        // strap pulled low after a normal boot; latched mode must not move
        boot(1'b0);
        @(posedge i_core_clk);
        glitch <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        axi_rd(`RBMS_STAT_OFS, d, r);
        check(32'(d[`RBMS_STAT_MODE_BIT]), 32'h0);
        glitch <= 1'b0;
        axi_wr(`RBMS_CTRL_OFS, 32'h0000_0020, r);
        axi_rd(`RBMS_CTRL_OFS, d, r);
        check(d, 32'h0000_0020);
        axi_rd(8'h40, d, r);
        check({d, 30'h0, r} == {32'h0, 30'h0, 2'h2}, 1'b1);
        axi_wr(8'h40, 32'h0000_0001, r);
        check(32'(r), 32'h2);
        report_and_stop;
    end

    // data steered from the selected source
    task automatic e_chk(input rbms_row_t w);
        logic [7:0] x;
        x = w.isel ? id(w.addr) : xd(w.addr);
        check(32'(o_cpu_rsp.rdata), 32'(x));
    endtask
endmodule // reset_boot_mode_memory_select_test
`default_nettype wire
